// ===== design/raw_ctrl.sv
// RTC configuration register, alarm flag and watchdog output control
//
// Notes on behaviour
// - Oscillator runs while stop bit is zero
// - Alarm armed only with a mode bit set
// - Mode: none, minutes, hours, both match
// - Matching increment sets the alarm flag
// - Interrupt held until status register read
// - Watchdog reaching zero sets the flag
// - Host writes flag zero, releasing watchdog pin
// - Enable bit runs watchdog; off means released
// - Contents restored from flash, factory value zero
// - Alarm flag bit 14, cleared on read
`timescale 1ns/1ps
`default_nettype none
module raw_ctrl (
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rst,
    // Serial command port pins
    input  wire logic           sclk,
    input  wire logic           cs_n,
    input  wire logic           mosi,
    output logic                miso,
    // Timebase pins
    input  wire logic           xin,
    input  wire logic           osc32_in,
    output logic                osc_run,
    output logic                clk32_out,
    // Timekeeping counters and interrupt enable
    input  wire raw_pkg::raw_tod_s tod,
    input  wire logic           int_enable,
    output logic                int_n,
    // Watchdog counter and pin
    input  wire logic           wd_zero,
    output logic                watchdog_out_n,
    output logic                watchdog_out_oe_n,
    output logic                watchdog_run,
    // Flash image of the configuration word
    input  wire logic           flash_load,
    input  wire logic [15:0]    flash_word,
    output logic [15:0]         cfg_word
);
    import raw_pkg::*;

    raw_state_s              st;        // Registered state
    raw_state_s              next_st;   // Next state
    logic [RAW_SYNC_W-1:0]   pins_s;    // Filtered pin levels
    logic                    sclk_s;    // Filtered serial clock
    logic                    rise;      // Serial clock rising edge
    logic                    fall;      // Serial clock falling edge
    logic [15:0]             word_in;   // Received data word
    logic                    alarm_set; // Alarm match event
    logic                    wd_flag_set; // Watchdog expiry event
    logic [1:0]              am;        // Alarm mode field
    logic                    min_eq;    // Minutes equal alarm
    logic                    hour_eq;   // Hours equal alarm
    logic                    slow_clk;  // Selected 32 kHz source

    // Every pin from outside passes the filter; chip select idles high
    raw_sync #(
        .W       (RAW_SYNC_W),
        .RST_VAL (RAW_SYNC_RESET)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({osc32_in, xin, mosi, cs_n, sclk}),
        .dout (pins_s)
    );

    assign sclk_s = pins_s[RAW_LN_SCLK];

    // Edge detection on the filtered serial clock
    assign rise = sclk_s & ~st.sclk_prev;
    assign fall = ~sclk_s & st.sclk_prev;

    // Word as it stands after this rising edge
    assign word_in = {st.shift_in[14:0], pins_s[RAW_LN_MOSI]};

    // Alarm compare fires only on an increment of the counters
    // Equality alone is not enough: a flag cleared by a status read
    // would otherwise be set again at once while the time still matches
    assign am      = st.cfg[RAW_BIT_AM_HI:RAW_BIT_AM_LO];
    assign min_eq  = (tod.cur_min == tod.alarm_min);
    assign hour_eq = (tod.cur_hour == tod.alarm_hour);
    always_comb begin
        case (am)
            RAW_AM_MIN:  alarm_set = tod.minute_inc & min_eq;
            RAW_AM_HOUR: alarm_set = tod.hour_inc & hour_eq;
            RAW_AM_BOTH: alarm_set = (tod.minute_inc | tod.hour_inc) & min_eq & hour_eq;
            default:     alarm_set = 1'b0;
        endcase
    end

    // Expiry only counts while the watchdog is enabled
    assign wd_flag_set = wd_zero & st.cfg[RAW_BIT_WD_ON];

    // Bypass picks the crystal pin; internal source only while running
    assign slow_clk = st.cfg[RAW_BIT_BYPASS] ? pins_s[RAW_LN_XIN]
                                             : (pins_s[RAW_LN_OSC] & st.osc_run);

    // Timing of a frame: the pin filter delays clock and data alike,
    // so their order survives; each serial clock phase must last two
    // clocks or more, or the filter swallows the edge.
    // A frame cut short by chip select never touches the register,
    // which costs the host nothing but a resend.
    // Next-state logic: serial port, flags and pin controls
    always_comb begin
        next_st           = st;
        next_st.sclk_prev = sclk_s;

        if (pins_s[RAW_LN_CS_N]) begin
            // Deselect aborts any partial frame
            next_st.phase   = RAW_ST_OPCODE;
            next_st.bit_cnt = 5'h00;
            // Leftover reply bits must not leak into a refused frame
            next_st.shift_out = RAW_STAT_RESET;
        end else if (rise) begin
            next_st.shift_in = word_in;
            next_st.bit_cnt  = st.bit_cnt + 5'h01;
            case (st.phase)
                RAW_ST_OPCODE: begin
                    if (st.bit_cnt == RAW_OPCODE_BITS - 5'h01) begin
                        next_st.opcode = word_in[7:0];
                        next_st.phase  = RAW_ST_DATA;
                        case (word_in[7:0])
                            RAW_OP_RD_CFG: begin
                                next_st.shift_out = st.cfg & RAW_CFG_MASK;
                            end
                            RAW_OP_RD_STAT: begin
                                next_st.shift_out = RAW_STAT_RESET;
                                next_st.shift_out[RAW_STAT_ALARM] = st.alarm_hit_flag;
                                next_st.alarm_hit_flag = 1'b0;
                                next_st.int_n          = 1'b1;
                            end
                            RAW_OP_WR_CFG: begin
                                next_st.shift_out = RAW_STAT_RESET;
                            end
                            default: begin
                                // Unknown opcodes sink the frame
                                next_st.phase = RAW_ST_IGNORE;
                            end
                        endcase
                    end
                end
                RAW_ST_DATA: begin
                    if (st.bit_cnt == RAW_FRAME_BITS - 5'h01) begin
                        next_st.phase = RAW_ST_IGNORE;
                        if (st.opcode == RAW_OP_WR_CFG) begin
                            next_st.cfg = word_in & RAW_CFG_MASK;
                            // Software can only clear the flag, never set it
                            next_st.cfg[RAW_BIT_WD_FLAG] = st.cfg[RAW_BIT_WD_FLAG] & word_in[RAW_BIT_WD_FLAG];
                        end
                    end
                end
                default: begin
                    // Extra clocks after a frame are ignored
                    next_st.bit_cnt = st.bit_cnt;
                end
            endcase
        end else if (fall && st.phase == RAW_ST_DATA) begin
            // Next outgoing bit moves on the falling edge
            next_st.shift_out = {st.shift_out[14:0], 1'b0};
        end

        // Flash restore replaces the whole word
        if (flash_load) begin
            next_st.cfg = flash_word & RAW_CFG_MASK;
        end

        // Hardware sets win over software clears
        if (alarm_set) begin
            next_st.alarm_hit_flag = 1'b1;
            // A match with interrupts off never releases a held request
            if (int_enable) begin
                next_st.int_n = 1'b0;
            end
        end
        if (wd_flag_set) begin
            next_st.cfg[RAW_BIT_WD_FLAG] = 1'b1;
        end

        // Pin controls follow the new configuration, except clk32_out, which is gated by the current one
        next_st.miso      = next_st.shift_out[15];
        next_st.osc_run   = ~next_st.cfg[RAW_BIT_OSC_STOP];
        next_st.wd_pin_oe_n = ~(next_st.cfg[RAW_BIT_WD_ON] & next_st.cfg[RAW_BIT_WD_FLAG]);
        next_st.clk32_out = slow_clk & st.cfg[RAW_BIT_CLK_EN];
    end

    // State register; reset gives the factory word of zeros
    // Only constants enter the reset branch, so any state, however
    // confused, is rebuilt in a single clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            st                <= '0;
            st.phase          <= RAW_ST_OPCODE;
            st.cfg            <= RAW_CFG_RESET;
            st.int_n          <= 1'b1;
            st.wd_pin_oe_n    <= 1'b1;
            st.osc_run        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flip-flops, except the constant watchdog_out_n
    assign miso              = st.miso;
    assign osc_run           = st.osc_run;
    assign clk32_out         = st.clk32_out;
    assign int_n             = st.int_n;
    assign watchdog_out_n    = 1'b0;        // Pin only ever pulls low
    assign watchdog_out_oe_n = st.wd_pin_oe_n;
    assign watchdog_run      = st.cfg[RAW_BIT_WD_ON];
    assign cfg_word          = st.cfg;
endmodule
`default_nettype wire

// ===== design/raw_pkg.sv
// Constants and carrier types for the RTC alarm and watchdog control block
package raw_pkg;
    // Serial command opcodes
    localparam logic [7:0]  RAW_OP_WR_CFG     = 8'h43;
    localparam logic [7:0]  RAW_OP_RD_CFG     = 8'hC3;
    localparam logic [7:0]  RAW_OP_RD_STAT    = 8'hFE;
    // Frame lengths in serial clocks
    localparam logic [4:0]  RAW_OPCODE_BITS   = 5'h08;
    localparam logic [4:0]  RAW_FRAME_BITS    = 5'h18;
    // Configuration word layout
    localparam int          RAW_BIT_WD_ON     = 0;
    localparam int          RAW_BIT_WD_FLAG   = 1;
    localparam int          RAW_BIT_AM_LO     = 2;
    localparam int          RAW_BIT_AM_HI     = 3;
    localparam int          RAW_BIT_OSC_STOP  = 4;
    localparam int          RAW_BIT_CLK_EN    = 5;
    localparam int          RAW_BIT_BYPASS    = 6;
    localparam logic [15:0] RAW_CFG_RESET     = 16'h0000;
    localparam logic [15:0] RAW_CFG_MASK      = 16'h007F;
    // Interrupt status layout
    localparam int          RAW_STAT_ALARM    = 14;
    localparam logic [15:0] RAW_STAT_RESET    = 16'h0000;
    // Alarm mode encodings
    localparam logic [1:0]  RAW_AM_NONE       = 2'h0;
    localparam logic [1:0]  RAW_AM_MIN        = 2'h1;
    localparam logic [1:0]  RAW_AM_HOUR       = 2'h2;
    localparam logic [1:0]  RAW_AM_BOTH       = 2'h3;
    // Synchroniser width and lane positions
    localparam int          RAW_SYNC_W        = 5;
    localparam int          RAW_LN_SCLK       = 0;
    localparam int          RAW_LN_CS_N       = 1;
    localparam int          RAW_LN_MOSI       = 2;
    localparam int          RAW_LN_XIN        = 3;
    localparam int          RAW_LN_OSC        = 4;
    localparam logic [4:0]  RAW_SYNC_RESET    = 5'h02;

    // Serial link phase
    typedef enum logic [1:0] {
        RAW_ST_OPCODE,
        RAW_ST_DATA,
        RAW_ST_IGNORE
    } raw_phase_e;

    // Time-of-day inputs from the timekeeping counters
    typedef struct packed {
        logic       minute_inc;
        logic       hour_inc;
        logic [6:0] cur_min;
        logic [5:0] cur_hour;
        logic [6:0] alarm_min;
        logic [5:0] alarm_hour;
    } raw_tod_s;

    // Whole state of the control block
    typedef struct packed {
        raw_phase_e  phase;
        logic [4:0]  bit_cnt;
        logic [7:0]  opcode;
        logic [15:0] shift_in;
        logic [15:0] shift_out;
        logic        sclk_prev;
        logic [15:0] cfg;
        logic        alarm_hit_flag;
        logic        miso;
        logic        int_n;
        logic        wd_pin_oe_n;
        logic        osc_run;
        logic        clk32_out;
    } raw_state_s;
endpackage

// ===== design/raw_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module raw_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Raw and filtered levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // One lane: three stages plus filtered level
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } raw_lane_s;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_lane
            raw_lane_s st;        // Lane state
            raw_lane_s next_st;   // Lane next state

            // Filter takes a new level only once stages two and three agree
            always_comb begin
                next_st    = st;
                next_st.s1 = din[g];
                next_st.s2 = st.s1;
                next_st.s3 = st.s2;
                if (st.s2 == st.s3) begin
                    next_st.q = st.s3;
                end
            end

            // Reset loads the idle level into every stage
            always_ff @(posedge mclk) begin
                if (rst) begin
                    st <= {4{RST_VAL[g]}};
                end else begin
                    st <= next_st;
                end
            end

            assign dout[g] = st.q;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== test/raw_ctrl_props.sv
// Checker for the RTC control block ports
`timescale 1ns/1ps
`default_nettype none
module raw_ctrl_props
    import raw_pkg::*;
(
    // All observed ports
    input wire logic             mclk, rst, sclk, cs_n, mosi, miso, xin, osc32_in, osc_run, clk32_out,
    input wire raw_pkg::raw_tod_s tod,
    input wire logic             int_enable, int_n, wd_zero, watchdog_out_n, watchdog_out_oe_n,
    input wire logic             watchdog_run, flash_load,
    input wire logic [15:0]      flash_word, cfg_word
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_osc_follow: assert property ($stable(cfg_word) [*2] |-> osc_run == !cfg_word[RAW_BIT_OSC_STOP])
        else $error("oscillator run does not follow stop bit");
    chk_int_cause: assert property ($fell(int_n) |-> $past(int_enable) && $past(cfg_word[3:2]) != RAW_AM_NONE)
        else $error("interrupt without armed alarm");
    chk_min_match: assert property (tod.minute_inc && tod.cur_min == tod.alarm_min && int_enable
        && cfg_word[3:2] == RAW_AM_MIN |=> !int_n) else $error("minute match gave no interrupt");
    chk_hour_match: assert property (tod.hour_inc && tod.cur_hour == tod.alarm_hour && int_enable
        && cfg_word[3:2] == RAW_AM_HOUR |=> !int_n) else $error("hour match gave no interrupt");
    chk_wdflag_set: assert property (wd_zero && cfg_word[RAW_BIT_WD_ON] && !flash_load
        |=> cfg_word[RAW_BIT_WD_FLAG]) else $error("watchdog expiry did not set flag");
    chk_wdpin_low: assert property ((cfg_word[1:0] == 2'h3) [*2] |-> !watchdog_out_oe_n)
        else $error("watchdog pin not driven");
    chk_wdpin_free: assert property ((cfg_word[1:0] != 2'h3) [*2] |-> watchdog_out_oe_n)
        else $error("watchdog pin not released");
    chk_wdpin_level: assert property (watchdog_out_n == 1'b0)
        else $error("watchdog pin data not low");
    chk_run_follow: assert property ($stable(cfg_word) [*2] |-> watchdog_run == cfg_word[RAW_BIT_WD_ON])
        else $error("watchdog run does not follow enable");
    chk_rsvd_zero: assert property (cfg_word[15:7] == 9'h000)
        else $error("reserved bits not zero");
    chk_clk_quiet: assert property (!cfg_word[RAW_BIT_CLK_EN] [*2] |-> !clk32_out)
        else $error("clock output active while disabled");
endmodule
bind raw_ctrl raw_ctrl_props u_props (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .xin(xin), .osc32_in(osc32_in), .osc_run(osc_run), .clk32_out(clk32_out), .tod(tod),
    .int_enable(int_enable), .int_n(int_n), .wd_zero(wd_zero), .watchdog_out_n(watchdog_out_n),
    .watchdog_out_oe_n(watchdog_out_oe_n), .watchdog_run(watchdog_run), .flash_load(flash_load),
    .flash_word(flash_word), .cfg_word(cfg_word));
`default_nettype wire

// ===== test/raw_host.sv
// Host model issuing serial command frames
`timescale 1ns/1ps
`default_nettype none
module raw_host (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [23:0] sh; // Frame bits, opcode first
    initial begin
        sclk = 1'b0; // Clock stands still low outside frames
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Frame of nb clocks; ten cycles per phase clears the input filter; nb below 24 cuts it
    task automatic xfer(input logic [7:0] op, input logic [15:0] wd, output logic [15:0] rd, input int nb);
        rd = 16'h0000;
        sh = {op, wd};
        @(negedge mclk) cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            @(negedge mclk) mosi = sh[23 - i];
            repeat (10) @(negedge mclk);
            sclk = 1'b1;
            repeat (10) @(negedge mclk);
            if (i >= 7 && i <= 22)
                rd[22 - i] = miso; // Reply sampled at end of high phase, settled since the previous sclk edge
            sclk = 1'b0;
        end
        repeat (10) @(negedge mclk);
        cs_n = 1'b1;
        mosi = ~mosi; // Released line shows no stale value
        repeat (10) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the RTC control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import raw_pkg::*;
    logic        mclk = 1'b0; // Clock
    logic        rst, sclk, cs_n, mosi, miso, xin, osc32_in, osc_run, clk32_out;
    raw_tod_s    tod;         // Time-of-day inputs
    logic        int_enable, int_n, wd_zero, wd_pin_n, wd_pin_oe_n, wd_run, flash_load;
    logic [15:0] flash_word, cfg_word, rd;
    int          err_count = 0;
    int          samples_checked = 0;
    always #5 mclk = ~mclk;
    raw_host u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    raw_ctrl u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .xin(xin),
        .osc32_in(osc32_in), .osc_run(osc_run), .clk32_out(clk32_out), .tod(tod), .int_enable(int_enable),
        .int_n(int_n), .wd_zero(wd_zero), .watchdog_out_n(wd_pin_n), .watchdog_out_oe_n(wd_pin_oe_n),
        .watchdog_run(wd_run), .flash_load(flash_load), .flash_word(flash_word), .cfg_word(cfg_word));
    // Config write frame
    task automatic wr(input logic [15:0] v);
        u_host.xfer(RAW_OP_WR_CFG, v, rd, 24);
    endtask
    // One-cycle pulse: 0 minute, 1 hour, 2 watchdog zero
    task automatic tick(input logic [1:0] w);
        @(negedge mclk);
        tod.minute_inc = (w == 2'h0);
        tod.hour_inc = (w == 2'h1);
        wd_zero = (w == 2'h2);
        @(negedge mclk);
        {tod.minute_inc, tod.hour_inc, wd_zero} = 3'h0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic t_reset;
        `CHK(cfg_word, RAW_CFG_RESET)
        `CHK({osc_run, int_n, wd_pin_oe_n, wd_run, clk32_out}, 5'h1C)
    endtask
    task automatic t_cfg;
        wr(16'hFFFF);
        `CHK({cfg_word, osc_run, wd_run}, {16'h007D, 2'h1})
        u_host.xfer(RAW_OP_RD_CFG, 16'h0000, rd, 24);
        `CHK(rd, 16'h007D)
        xin = 1'b1;
        repeat (12) @(negedge mclk);
        `CHK(clk32_out, 1'b1)
        wr(16'h0020);
        `CHK(clk32_out, 1'b0)
        osc32_in = 1'b1;
        repeat (12) @(negedge mclk);
        `CHK(clk32_out, 1'b1)
        wr(16'h0000);
        `CHK({clk32_out, osc_run}, 2'h1)
    endtask
    // Refused frames: unknown opcode, then a write cut one clock short
    task automatic t_refuse;
        wr(16'h0010);
        u_host.xfer(8'h00, 16'h0001, rd, 24);
        `CHK({rd, cfg_word}, {16'h0000, 16'h0010})
        u_host.xfer(RAW_OP_WR_CFG, 16'h0001, rd, 23);
        `CHK(cfg_word, 16'h0010)
        u_host.xfer(RAW_OP_RD_CFG, 16'h0000, rd, 24);
        `CHK(rd, 16'h0010)
        wr(16'h0000);
    endtask
    task automatic t_wdog;
        wr(16'h0001);
        tick(2'h2);
        `CHK({cfg_word[1], wd_pin_oe_n}, 2'h2)
        wr(16'h0003);
        `CHK(wd_pin_oe_n, 1'b0)
        wr(16'h0001);
        `CHK({cfg_word[1], wd_pin_oe_n}, 2'h1)
        tick(2'h2);
        wr(16'h0002);
        `CHK({wd_run, cfg_word[1], wd_pin_oe_n}, 3'h3)
        wr(16'h0000);
    endtask
    task automatic t_alarm;
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr({12'h000, m, 2'h0});
            tick(2'h0);
            `CHK(int_n, !m[0])
            u_host.xfer(RAW_OP_RD_STAT, 16'h0000, rd, 24);
            `CHK({rd, int_n}, {1'b0, m[0], 15'h0001})
            tick(2'h1);
            `CHK(int_n, !m[1])
            u_host.xfer(RAW_OP_RD_STAT, 16'h0000, rd, 24);
            `CHK({rd[14], int_n}, {m[1], 1'b1})
        end
        // Held interrupt survives a match with interrupts off; flag still sets
        wr(16'h0004);
        tick(2'h0);
        int_enable = 1'b0;
        tick(2'h0);
        `CHK(int_n, 1'b0)
        u_host.xfer(RAW_OP_RD_STAT, 16'h0000, rd, 24);
        tick(2'h0);
        `CHK({rd[14], int_n}, 2'h3)
        u_host.xfer(RAW_OP_RD_STAT, 16'h0000, rd, 24);
        `CHK(rd[14], 1'b1)
        int_enable = 1'b1;
    endtask
    task automatic t_flash;
        @(negedge mclk);
        flash_word = 16'h0014;
        flash_load = 1'b1;
        @(negedge mclk);
        flash_load = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK({cfg_word, osc_run}, {16'h0014, 1'b0})
        // Mid-run reset brings back the factory word
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        `CHK({cfg_word, osc_run}, {RAW_CFG_RESET, 1'b1})
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {xin, osc32_in, int_enable, wd_zero, flash_load, flash_word} = {5'h04, 16'h0000};
        tod = {2'h0, 7'h2A, 6'h11, 7'h2A, 6'h11};
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        repeat (8) @(negedge mclk);
        t_reset;
        t_cfg;
        t_refuse;
        t_wdog;
        t_alarm;
        t_flash;
        tally_and_finish;
    end
    // Hang guard
    initial begin
        #600000;
        err_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
